// [verilog/cam_filter_system_regs.sv]
// system register bank of the cam address-filter controller
//
// Summary of operation
// - speed grade field at static bits 3:1
// - static bit 0 inverts frame drop polarity
// - cam reset pin follows dynamic bit 0
// - hardware reset holds cam reset low
// - target bits 3:2 gate stamp input
// - target bits 1:0 gate full interrupt
// - lookup associated data reloads data word 0
// - associated data field layout in word 0
// - purge stamp counter, reset 01H, bumpable
// - current stamp counter, reset 00H, bumpable
// - six-bit lookup cycle budget field
// - entry read captures cam status halves
// - two source opcode registers with defaults
// - control bit 4 hands lines to processor
// - command register write starts routine, except current stamp bump
// - purge bumps also start purge routine
// - ready held off during priority search
// - timing relative to 50 MHz reference
// - accesses ignored until role set to zero
`include "cam_sys_cfg.svh"
module cam_filter_system_regs (
    // clock and reset
    input  wire logic        clock,
    input  wire logic        resetn,
    // processor port, system chip select
    input  wire logic        sys_select,
    input  wire logic        write_strobe,
    input  wire logic        read_strobe,
    input  wire logic [5:0]  address,
    input  wire logic [15:0] write_data,
    output logic      [15:0] read_data,
    output logic             host_ready,
    // chip role field, from the chip register block
    input  wire logic [2:0]  role_select,
    // cam array pins
    input  wire logic        array_full_flag_n,
    input  wire logic        array_match_flag_n,
    output logic             cam_chain_reset_n,
    output logic             full_irq_out_n,
    output logic             chain_enable_n,
    output logic             command_mode_n,
    output logic             write_select_n,
    output logic             cycle_strobe_n,
    output logic             processor_owns_lines,
    // frame filter side
    input  wire logic        frame_reject,
    output logic             frame_drop_out,
    input  wire logic        stamp_advance_in,
    input  wire logic        priority_search_busy,
    // routine engine side
    output cam_sys_pkg::routine_e routine_start,
    output cam_sys_pkg::speed_e   cam_speed_grade,
    output logic      [5:0]  lookup_cycles,
    output logic      [5:0]  lookup_ref_cycles,
    output logic      [15:0] source_update_opcode,
    output logic      [15:0] source_learn_opcode,
    output logic      [15:0] data_word_0_out,
    output logic      [15:0] data_word_1_out,
    output logic      [15:0] data_word_2_out,
    output logic      [15:0] data_word_3_out,
    output logic      [7:0]  current_stamp,
    output logic      [7:0]  purge_stamp,
    input  wire logic        lookup_done,
    input  wire logic [15:0] lookup_assoc_data,
    input  wire logic        entry_read_done,
    input  wire logic [31:0] entry_status
);
    // ---------------------------------------------------------------
    // access decode
    // ---------------------------------------------------------------
    logic              access_ok;
    logic              wr;
    logic              rd;
    logic [3:0]        static_configuration;
    logic              dynamic_configuration;
    logic [3:0]        event_targets;
    logic [15:0]       data_word [0:3];
    logic [5:0]        max_lookup_cycles;
    logic [15:0]       cam_status_low;
    logic [15:0]       cam_status_high;
    logic [4:0]        cam_control_lines;
    logic              stamp_pin_enabled;
    logic              stamp_pin_pulse;
    cam_sys_pkg::routine_e next_routine;

    stamp_if st ();

    // matches one register index
    function automatic logic hit(input logic [5:0] a, input logic [5:0] idx);
        hit = (a == idx);
    endfunction

    // role must be cleared before system accesses count
    assign access_ok = (role_select == 3'h0);
    assign wr        = sys_select && write_strobe && access_ok;
    assign rd        = sys_select && read_strobe && access_ok;

    // ready withheld while a priority search runs
    assign host_ready = !priority_search_busy;

    // ---------------------------------------------------------------
    // configuration registers
    // ---------------------------------------------------------------
    // static configuration: speed grade and reject polarity
    always_ff @(posedge clock or negedge resetn) begin
        if (!resetn) begin
            static_configuration <= `RST_STATIC;
        end else if (wr && hit(address, `ADDR_STATIC_CFG)) begin
            static_configuration <= write_data[3:0];
        end
    end

    // dynamic configuration: cam reset release
    always_ff @(posedge clock or negedge resetn) begin
        if (!resetn) begin
            dynamic_configuration <= 1'b0;
        end else if (wr && hit(address, `ADDR_DYNAMIC_CFG)) begin
            dynamic_configuration <= write_data[`RELEASE_BIT];
        end
    end

    // event targets: stamp pin and full interrupt gating
    always_ff @(posedge clock or negedge resetn) begin
        if (!resetn) begin
            event_targets <= `RST_TARGETS;
        end else if (wr && hit(address, `ADDR_TARGETS)) begin
            event_targets <= write_data[3:0];
        end
    end

    // lookup cycle budget
    always_ff @(posedge clock or negedge resetn) begin
        if (!resetn) begin
            max_lookup_cycles <= `RST_LOOKUP;
        end else if (wr && hit(address, `ADDR_LOOKUP_CYC)) begin
            max_lookup_cycles <= write_data[5:0];
        end
    end

    // source address opcodes
    always_ff @(posedge clock or negedge resetn) begin
        if (!resetn) begin
            source_update_opcode <= `RST_SRC_UPD;
            source_learn_opcode  <= `RST_SRC_LRN;
        end else if (wr && hit(address, `ADDR_SRC_UPDATE)) begin
            source_update_opcode <= write_data;
        end else if (wr && hit(address, `ADDR_SRC_LEARN)) begin
            source_learn_opcode <= write_data;
        end
    end

    // manual control lines
    always_ff @(posedge clock or negedge resetn) begin
        if (!resetn) begin
            cam_control_lines <= `RST_CTRL;
        end else if (wr && hit(address, `ADDR_CTRL_LINES)) begin
            cam_control_lines <= write_data[4:0];
        end
    end

    // ---------------------------------------------------------------
    // data words and captured status
    // ---------------------------------------------------------------
    // data words: host writes, lookup reload of word 0 wins
    always_ff @(posedge clock or negedge resetn) begin
        if (!resetn) begin
            for (int i = 0; i < 4; i++) begin
                data_word[i] <= 16'h0000;
            end
        end else begin
            if (wr && address >= `ADDR_DATA_WORD0 && address <= `ADDR_DATA_WORD3) begin
                data_word[2'(address - `ADDR_DATA_WORD0)] <= write_data;
            end
            if (lookup_done) begin
                data_word[0] <= lookup_assoc_data;
            end
        end
    end

    // status capture after entry read
    always_ff @(posedge clock or negedge resetn) begin
        if (!resetn) begin
            cam_status_low  <= 16'h0000;
            cam_status_high <= 16'h0000;
        end else if (entry_read_done) begin
            cam_status_low  <= entry_status[15:0];
            cam_status_high <= entry_status[31:16];
        end
    end

    // ---------------------------------------------------------------
    // commands and time stamps
    // ---------------------------------------------------------------
    assign stamp_pin_enabled = (event_targets[`STAMP_EN_MSB:`STAMP_EN_LSB] == `STAMP_EN_ON);
    assign stamp_pin_pulse   = stamp_pin_enabled && stamp_advance_in;

    // one bump per cycle per counter, whatever the sources
    assign st.bump_current = stamp_pin_pulse
                           || (wr && (hit(address, `ADDR_CMD_BUMP_CUR) || hit(address, `ADDR_CMD_BUMP_ALL)));
    assign st.bump_purge   = stamp_pin_pulse
                           || (wr && (hit(address, `ADDR_CMD_BUMP_PRG) || hit(address, `ADDR_CMD_BUMP_ALL)));

    stamp_counters counters (
        .clock  (clock),
        .resetn (resetn),
        .st     (st)
    );

    // command decode, written value ignored
    always_comb begin
        next_routine = cam_sys_pkg::ROUTINE_NONE;
        if (wr) begin
            case (address)
                `ADDR_CMD_DELETE:   next_routine = cam_sys_pkg::ROUTINE_DELETE;
                `ADDR_CMD_ADD:      next_routine = cam_sys_pkg::ROUTINE_ADD;
                `ADDR_CMD_READ:     next_routine = cam_sys_pkg::ROUTINE_READ;
                `ADDR_CMD_SET_ADDR: next_routine = cam_sys_pkg::ROUTINE_SET_ADDR;
                `ADDR_CMD_BUMP_PRG: next_routine = cam_sys_pkg::ROUTINE_PURGE;
                `ADDR_CMD_BUMP_ALL: next_routine = cam_sys_pkg::ROUTINE_PURGE;
                default:            next_routine = cam_sys_pkg::ROUTINE_NONE;
            endcase
        end
        if (next_routine == cam_sys_pkg::ROUTINE_NONE && stamp_pin_pulse) begin
            next_routine = cam_sys_pkg::ROUTINE_PURGE;
        end
    end

    // one-cycle routine start pulse
    always_ff @(posedge clock or negedge resetn) begin
        if (!resetn) begin
            routine_start <= cam_sys_pkg::ROUTINE_NONE;
        end else begin
            routine_start <= next_routine;
        end
    end

    // ---------------------------------------------------------------
    // read path
    // ---------------------------------------------------------------
    always_ff @(posedge clock or negedge resetn) begin
        if (!resetn) begin
            read_data <= 16'h0000;
        end else if (rd) begin
            case (address)
                `ADDR_STATUS:      read_data <= {14'h0000, array_match_flag_n, array_full_flag_n};
                6'h05:             read_data <= data_word[0];
                6'h06:             read_data <= data_word[1];
                6'h07:             read_data <= data_word[2];
                `ADDR_DATA_WORD3:  read_data <= data_word[3];
                `ADDR_PURGE_TS:    read_data <= {8'h00, st.purge_ts};
                `ADDR_CURRENT_TS:  read_data <= {8'h00, st.current_ts};
                `ADDR_STATUS_HIGH: read_data <= cam_status_high;
                `ADDR_STATUS_LOW:  read_data <= cam_status_low;
                default:           read_data <= 16'h0000;
            endcase
        end
    end

    // ---------------------------------------------------------------
    // pin outputs
    // ---------------------------------------------------------------
    // cam reset pin follows the release bit
    assign cam_chain_reset_n = dynamic_configuration;

    // frame reject polarity
    assign frame_drop_out = frame_reject ^ static_configuration[`DROP_INV_BIT];

    // speed grade decode, reserved codes flagged
    always_comb begin
        case (static_configuration[`SPEED_MSB:`SPEED_LSB])
            3'b000:  cam_speed_grade = cam_sys_pkg::SPEED_SLOW;
            3'b001:  cam_speed_grade = cam_sys_pkg::SPEED_90;
            3'b010:  cam_speed_grade = cam_sys_pkg::SPEED_70;
            default: cam_speed_grade = cam_sys_pkg::SPEED_RSVD;
        endcase
    end

    // budget counted in 50 MHz reference cycles
    assign lookup_ref_cycles = max_lookup_cycles;
    assign lookup_cycles     = max_lookup_cycles;

    // full interrupt gated by targets, active low
    assign full_irq_out_n = !((event_targets[`FULL_EN_MSB:`FULL_EN_LSB] == `FULL_EN_ON)
                              && !array_full_flag_n);

    // manual control lines only while processor owns them
    assign processor_owns_lines = cam_control_lines[`CTRL_OWN_BIT];
    assign chain_enable_n = processor_owns_lines ? cam_control_lines[0] : 1'b1;
    assign command_mode_n = processor_owns_lines ? cam_control_lines[1] : 1'b1;
    assign write_select_n = processor_owns_lines ? cam_control_lines[2] : 1'b1;
    assign cycle_strobe_n = processor_owns_lines ? cam_control_lines[3] : 1'b1;

    assign data_word_0_out = data_word[0];
    assign data_word_1_out = data_word[1];
    assign data_word_2_out = data_word[2];
    assign data_word_3_out = data_word[3];
    assign current_stamp   = st.current_ts;
    assign purge_stamp     = st.purge_ts;

    // ---------------------------------------------------------------
    // checks
    // ---------------------------------------------------------------
    AST_CAM_RESET: assert property (@(posedge clock) disable iff (!resetn)
        wr && hit(address, `ADDR_DYNAMIC_CFG) |=> cam_chain_reset_n == $past(write_data[0]))
        else $error("cam reset pin does not follow written bit");

    AST_ROLE_BLOCK: assert property (@(posedge clock) disable iff (!resetn)
        role_select != 3'h0 |=> $stable(dynamic_configuration) && $stable(static_configuration))
        else $error("register changed while role not cleared");

    AST_START: assert property (@(posedge clock) disable iff (!resetn)
        wr && hit(address, `ADDR_CMD_ADD) |=> routine_start == cam_sys_pkg::ROUTINE_ADD)
        else $error("add routine not started");

    AST_PURGE_START: assert property (@(posedge clock) disable iff (!resetn)
        wr && hit(address, `ADDR_CMD_BUMP_ALL) |=> routine_start == cam_sys_pkg::ROUTINE_PURGE)
        else $error("purge not started by combined bump");

    AST_RELOAD: assert property (@(posedge clock) disable iff (!resetn)
        lookup_done |=> data_word[0] == $past(lookup_assoc_data))
        else $error("word 0 not reloaded after lookup");

    AST_STATUS: assert property (@(posedge clock) disable iff (!resetn)
        entry_read_done |=> {cam_status_high, cam_status_low} == $past(entry_status))
        else $error("status halves not captured");

    AST_LINES: assert property (@(posedge clock) disable iff (!resetn)
        !processor_owns_lines |-> cycle_strobe_n && chain_enable_n)
        else $error("control lines driven without ownership");

    AST_FULL_IRQ: assert property (@(posedge clock) disable iff (!resetn)
        event_targets[1:0] != `FULL_EN_ON |-> full_irq_out_n)
        else $error("full interrupt raised while disabled");

    AST_STAMP_PIN: assert property (@(posedge clock) disable iff (!resetn)
        stamp_advance_in && event_targets[3:2] == `STAMP_EN_ON |=> purge_stamp == $past(purge_stamp) + 8'h01)
        else $error("enabled stamp pin did not advance purge stamp");
endmodule

// [verilog/cam_sys_cfg.svh]
// constants for the cam filter system register bank
`ifndef CAM_SYS_CFG_SVH
`define CAM_SYS_CFG_SVH
// register indexes (word address on the processor port)
`define ADDR_STATUS       6'h00
`define ADDR_STATIC_CFG   6'h01
`define ADDR_DYNAMIC_CFG  6'h02
`define ADDR_TARGETS      6'h03
`define ADDR_DATA_WORD0   6'h05
`define ADDR_DATA_WORD3   6'h08
`define ADDR_PURGE_TS     6'h09
`define ADDR_CURRENT_TS   6'h0A
`define ADDR_LOOKUP_CYC   6'h0C
`define ADDR_STATUS_HIGH  6'h0D
`define ADDR_STATUS_LOW   6'h0E
`define ADDR_SRC_UPDATE   6'h10
`define ADDR_SRC_LEARN    6'h11
`define ADDR_CTRL_LINES   6'h12
`define ADDR_CMD_DELETE   6'h20
`define ADDR_CMD_ADD      6'h21
`define ADDR_CMD_READ     6'h24
`define ADDR_CMD_BUMP_CUR 6'h26
`define ADDR_CMD_BUMP_PRG 6'h27
`define ADDR_CMD_BUMP_ALL 6'h28
`define ADDR_CMD_SET_ADDR 6'h29
// field positions
`define SPEED_MSB     3
`define SPEED_LSB     1
`define DROP_INV_BIT  0
`define RELEASE_BIT   0
`define STAMP_EN_MSB  3
`define STAMP_EN_LSB  2
`define FULL_EN_MSB   1
`define FULL_EN_LSB   0
`define CTRL_OWN_BIT  4
// field codes
`define STAMP_EN_ON   2'h3
`define FULL_EN_ON    2'h2
// reset values
`define RST_STATIC    4'h0
`define RST_TARGETS   4'h0
`define RST_PURGE_TS  8'h01
`define RST_CURR_TS   8'h00
`define RST_LOOKUP    6'h20
`define RST_SRC_UPD   16'h0368
`define RST_SRC_LRN   16'h0334
`define RST_CTRL      5'h0F
// timing: cycle budget interpreted against a 50 MHz reference
`define REF_CLOCK_MHZ 50
`define SYS_CLOCK_MHZ 200
`endif

// [verilog/cam_sys_pkg.sv]
// types for the cam filter system register bank
package cam_sys_pkg;
    typedef enum logic [2:0] {
        ROUTINE_NONE      = 3'b000,
        ROUTINE_DELETE    = 3'b001,
        ROUTINE_ADD       = 3'b010,
        ROUTINE_READ      = 3'b011,
        ROUTINE_SET_ADDR  = 3'b100,
        ROUTINE_PURGE     = 3'b101
    } routine_e;
    typedef enum logic [1:0] {
        SPEED_SLOW = 2'b00,
        SPEED_90   = 2'b01,
        SPEED_70   = 2'b10,
        SPEED_RSVD = 2'b11
    } speed_e;
endpackage

// [verilog/stamp_if.sv]
// carries time-stamp advance requests and counter values
interface stamp_if;
    logic       bump_current;
    logic       bump_purge;
    logic [7:0] current_ts;
    logic [7:0] purge_ts;
    modport owner (input bump_current, input bump_purge, output current_ts, output purge_ts);
    modport user  (output bump_current, output bump_purge, input current_ts, input purge_ts);
endinterface

// [verilog/stamp_counters.sv]
// purge and current time-stamp counters
`include "cam_sys_cfg.svh"
module stamp_counters (
    // clock and reset
    input  wire logic clock,
    input  wire logic resetn,
    // requests and values
    stamp_if.owner    st
);
    // current counter, one step per cycle, wraps naturally
    always_ff @(posedge clock or negedge resetn) begin
        if (!resetn) begin
            st.current_ts <= `RST_CURR_TS;
        end else if (st.bump_current) begin
            st.current_ts <= st.current_ts + 8'h01;
        end
    end

    // purge counter, one step per cycle, wraps naturally
    always_ff @(posedge clock or negedge resetn) begin
        if (!resetn) begin
            st.purge_ts <= `RST_PURGE_TS;
        end else if (st.bump_purge) begin
            st.purge_ts <= st.purge_ts + 8'h01;
        end
    end

    AST_PURGE_STEP: assert property (@(posedge clock) disable iff (!resetn)
        st.bump_purge |=> st.purge_ts == $past(st.purge_ts) + 8'h01)
        else $error("purge stamp did not advance by one");
    AST_CURR_HOLD: assert property (@(posedge clock) disable iff (!resetn)
        !st.bump_current |=> $stable(st.current_ts))
        else $error("current stamp moved without request");
endmodule

// [test/cam_chain_model.sv]
// behavioural cam chain and routine engine facing the register bank
module cam_chain_model (
    // clock and reset
    input  wire logic             clock,
    input  wire logic             resetn,
    // bank side
    input  wire logic             cam_chain_reset_n,
    input  cam_sys_pkg::routine_e routine_start,
    output logic                  array_full_flag_n,
    output logic                  lookup_done,
    output logic [15:0]           lookup_assoc_data,
    output logic                  entry_read_done,
    output logic [31:0]           entry_status,
    // bench controls
    input  wire logic             full_req,
    input  wire logic             lookup_req,
    input  wire logic [15:0]      assoc_val,
    input  wire logic [31:0]      status_val
);
    timeunit 1ns;
    timeprecision 100ps;
    // a chain held in reset raises no full flag
    assign array_full_flag_n = !(cam_chain_reset_n && full_req);
    // answers one cycle after the request, idle data shows inverted
    always_ff @(posedge clock or negedge resetn) begin
        if (!resetn) begin
            lookup_done       <= 1'b0;
            lookup_assoc_data <= 16'h0000;
            entry_read_done   <= 1'b0;
            entry_status      <= 32'h0;
        end else begin
            lookup_done       <= lookup_req;
            lookup_assoc_data <= lookup_req ? assoc_val : ~lookup_assoc_data;
            entry_read_done   <= (routine_start == cam_sys_pkg::ROUTINE_READ);
            entry_status      <= (routine_start == cam_sys_pkg::ROUTINE_READ) ? status_val : ~entry_status;
        end
    end
endmodule

// [test/cam_filter_system_regs_tb_top.sv]
// testbench for the cam filter system register bank
`include "cam_sys_cfg.svh"
module cam_filter_system_regs_tb_top;
    timeunit 1ns;
    timeprecision 100ps;
    logic clock, resetn, sys_select, write_strobe, read_strobe, frame_reject, stamp_advance_in;
    logic priority_search_busy, full_req, lookup_req, host_ready, array_full_flag_n, cam_chain_reset_n;
    logic full_irq_out_n, chain_enable_n, command_mode_n, write_select_n, cycle_strobe_n;
    logic processor_owns_lines, frame_drop_out, lookup_done, entry_read_done;
    logic [15:0] write_data, read_data, source_update_opcode, source_learn_opcode, lookup_assoc_data;
    logic [15:0] data_word_0_out, data_word_1_out, data_word_2_out, data_word_3_out, assoc_val, rv;
    logic [15:0] words [4];
    logic [5:0]  address, lookup_cycles, lookup_ref_cycles;
    logic [7:0]  current_stamp, purge_stamp, exp_cur, exp_prg;
    logic [31:0] entry_status, status_val, seed;
    logic [2:0]  role_select, rs;
    cam_sys_pkg::routine_e routine_start;
    cam_sys_pkg::speed_e   cam_speed_grade;
    int error_cnt, n_compared, cycles;
    logic [5:0] cmd_a [7] = '{6'h20, 6'h21, 6'h24, 6'h26, 6'h27, 6'h28, 6'h29};
    int         cmd_r [7] = '{1, 2, 3, -1, 5, 5, 4};
    int         cmd_c [7] = '{0, 0, 0, 1, 0, 1, 0};
    int         cmd_p [7] = '{0, 0, 0, 0, 1, 1, 0};

    cam_filter_system_regs dut (.clock, .resetn, .sys_select, .write_strobe, .read_strobe, .address,
        .write_data, .read_data, .host_ready, .role_select, .array_full_flag_n, .array_match_flag_n(1'b1),
        .cam_chain_reset_n, .full_irq_out_n, .chain_enable_n, .command_mode_n, .write_select_n,
        .cycle_strobe_n, .processor_owns_lines, .frame_reject, .frame_drop_out, .stamp_advance_in,
        .priority_search_busy, .routine_start, .cam_speed_grade, .lookup_cycles, .lookup_ref_cycles,
        .source_update_opcode, .source_learn_opcode, .data_word_0_out, .data_word_1_out,
        .data_word_2_out, .data_word_3_out, .current_stamp, .purge_stamp, .lookup_done,
        .lookup_assoc_data, .entry_read_done, .entry_status);
    cam_chain_model partner (.clock, .resetn, .cam_chain_reset_n, .routine_start, .array_full_flag_n,
        .lookup_done, .lookup_assoc_data, .entry_read_done, .entry_status, .full_req, .lookup_req,
        .assoc_val, .status_val);

    // ----------------------------------------
    // helpers
    // ----------------------------------------
    function automatic logic [31:0] lfsr(input logic [31:0] x);
        lfsr = {x[30:0], 1'b0} ^ (x[31] ? 32'h04C11DB7 : 32'h0);
    endfunction
    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        n_compared++;
        if (got !== exp) begin
            error_cnt++;
            $display("Error at %0t: got %h expected %h", $time, got, exp);
        end
    endtask
    // one host write, optional stamp pin pulse in the same cycle
    task automatic wr(input logic [5:0] a, input logic [15:0] d, input logic pin);
        sys_select <= 1'b1;
        write_strobe <= 1'b1;
        address <= a;
        write_data <= d;
        stamp_advance_in <= pin;
        @(posedge clock);
        sys_select <= 1'b0;
        write_strobe <= 1'b0;
        stamp_advance_in <= 1'b0;
        #1 rs = routine_start;
        @(posedge clock);
    endtask
    task automatic rd(input logic [5:0] a);
        sys_select <= 1'b1;
        read_strobe <= 1'b1;
        address <= a;
        @(posedge clock);
        sys_select <= 1'b0;
        read_strobe <= 1'b0;
        #1 rv = read_data;
        @(posedge clock);
    endtask
    task automatic results;
        if (error_cnt == 0 && n_compared > 0) begin
            $display("Testbench passed");
        end else begin
            $display("Testbench failed");
        end
        $finish;
    endtask

    // ----------------------------------------
    // clock, watchdog, sequence
    // ----------------------------------------
    initial begin
        clock = 1'b0;
        forever #2.5 clock = ~clock;
    end
    always @(posedge clock) begin
        cycles++;
        if (cycles == 5000) begin
            error_cnt++;
            results();
        end
    end
    initial begin
        {resetn, sys_select, write_strobe, read_strobe, frame_reject, stamp_advance_in} = 6'h0;
        {priority_search_busy, full_req, lookup_req, address, write_data} = 25'h0;
        {assoc_val, status_val, exp_cur, exp_prg} = 64'h0000_0000_0000_0001;
        role_select = 3'h1;
        seed = 32'h6E3547DE;
        repeat (6) @(posedge clock);
        chk(cam_chain_reset_n, 0);
        resetn <= 1'b1;
        wr(`ADDR_DYNAMIC_CFG, 16'h0001, 1'b0);
        wr(`ADDR_CMD_BUMP_PRG, 16'h0000, 1'b0);
        chk({cam_chain_reset_n, purge_stamp}, 9'h001);
        role_select <= 3'h0;
        rd(`ADDR_PURGE_TS);
        chk(rv, 16'h0001);
        rd(`ADDR_CURRENT_TS);
        chk(rv, 16'h0000);
        chk({source_update_opcode, source_learn_opcode}, 32'h0368_0334);
        chk(host_ready, 1);
        chk({processor_owns_lines, cycle_strobe_n, write_select_n, command_mode_n, chain_enable_n}, 5'h0F);
        wr(`ADDR_DYNAMIC_CFG, 16'h0001, 1'b0);
        chk(cam_chain_reset_n, 1);
        // speed grade and reject polarity over every code
        for (int i = 0; i < 16; i++) begin
            seed = lfsr(seed);
            frame_reject <= seed[0];
            wr(`ADDR_STATIC_CFG, 16'(i), 1'b0);
            chk(cam_speed_grade, (i / 2 > 2) ? 3 : i / 2);
            chk(frame_drop_out, seed[0] ^ i[0]);
        end
        // targets: full interrupt and stamp pin gating
        full_req <= 1'b1;
        for (int i = 0; i < 16; i++) begin
            wr(`ADDR_TARGETS, 16'(i), 1'b0);
            chk(full_irq_out_n, i[1:0] != 2'b10);
            wr(`ADDR_SRC_LEARN, 16'h0334, 1'b1);
            if (i[3:2] == 2'b11) begin
                exp_cur++;
                exp_prg++;
            end
            chk({current_stamp, purge_stamp}, {exp_cur, exp_prg});
        end
        rd(`ADDR_STATUS);
        chk(rv, 16'h0002);
        // pin and command bump in one cycle count once
        wr(`ADDR_CMD_BUMP_ALL, 16'hFFFF, 1'b1);
        exp_cur++;
        exp_prg++;
        chk({current_stamp, purge_stamp, rs}, {exp_cur, exp_prg, 3'h5});
        // command registers, random ignored data
        seed = lfsr(seed);
        status_val <= seed;
        for (int i = 0; i < 7; i++) begin
            seed = lfsr(seed);
            wr(cmd_a[i], seed[15:0], 1'b0);
            exp_cur += 8'(cmd_c[i]);
            exp_prg += 8'(cmd_p[i]);
            if (cmd_r[i] >= 0) chk(rs, cmd_r[i]);
            chk({current_stamp, purge_stamp}, {exp_cur, exp_prg});
        end
        rd(`ADDR_STATUS_LOW);
        chk(rv, status_val[15:0]);
        rd(`ADDR_STATUS_HIGH);
        chk(rv, status_val[31:16]);
        repeat (256) wr(`ADDR_CMD_BUMP_CUR, 16'h0000, 1'b0);
        rd(`ADDR_CURRENT_TS);
        chk(rv, {8'h00, exp_cur});
        // data words read back
        for (int w = 0; w < 4; w++) begin
            seed = lfsr(seed);
            words[w] = seed[15:0];
            wr(6'(`ADDR_DATA_WORD0 + w), words[w], 1'b0);
            rd(6'(`ADDR_DATA_WORD0 + w));
            chk(rv, words[w]);
        end
        chk({data_word_0_out, data_word_1_out, data_word_2_out, data_word_3_out},
            {words[0], words[1], words[2], words[3]});
        // lookup result reloads word 0
        assoc_val <= {1'b1, 1'b0, 6'h2A, 8'h5C};
        lookup_req <= 1'b1;
        @(posedge clock);
        lookup_req <= 1'b0;
        repeat (2) @(posedge clock);
        rd(`ADDR_DATA_WORD0);
        chk(rv, 16'hAA5C);
        // manual cam cycle on the control lines
        wr(`ADDR_CTRL_LINES, 16'h0019, 1'b0);
        chk({processor_owns_lines, cycle_strobe_n, write_select_n, command_mode_n, chain_enable_n}, 5'h19);
        wr(`ADDR_CTRL_LINES, 16'h0011, 1'b0);
        chk({processor_owns_lines, cycle_strobe_n, write_select_n, command_mode_n, chain_enable_n}, 5'h11);
        wr(`ADDR_CTRL_LINES, 16'h0007, 1'b0);
        chk({processor_owns_lines, cycle_strobe_n, write_select_n, command_mode_n, chain_enable_n}, 5'h0F);
        // opcodes, budget, unmapped and write-only reads
        wr(`ADDR_SRC_UPDATE, 16'hA5C3, 1'b0);
        wr(`ADDR_LOOKUP_CYC, 16'h0027, 1'b0);
        chk({source_update_opcode, lookup_cycles, lookup_ref_cycles}, {16'hA5C3, 6'h27, 6'h27});
        rd(6'h3F);
        chk(rv, 16'h0000);
        rd(`ADDR_STATIC_CFG);
        chk(rv, 16'h0000);
        priority_search_busy <= 1'b1;
        @(posedge clock);
        #1 chk(host_ready, 0);
        @(posedge clock);
        results();
    end
endmodule
